// ### core/cswm_device.sv
/*
  Device end: CAN transceiver mode control with selective wake, power
  mode tracking and the RXD/TXD path gating.
  Assumes the frame decoder and error counter outside deliver one-cycle
  event pulses synchronous to clk_i.
*/
`timescale 1ns/1ps
`default_nettype none

module cswm_device
  import cswm_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  cswm_if.dev link,
  input wire logic bus_rx_i,
  input wire logic txd_i,
  input wire logic wake_frame_i,
  input wire logic wake_pattern_i,
  input wire logic err_overflow_i,
  input wire logic bus_idle_i,
  input wire logic other_wake_i,
  input wire logic cfg_clear_i,
  output logic rxd_o,
  output logic bus_tx_o,
  output logic woken_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  cswm_pm_t pm, next_pm;
  cswm_xs_t xs, next_xs;
  logic [2:0] field, next_field;
  logic err, next_err;
  logic armed, next_armed;
  logic cfg, next_cfg;
  logic woken, next_woken;
  logic sil, next_sil;
  logic irq, next_irq;
  logic rxd, next_rxd;
  logic tx, next_tx;
  logic swk_on;
  logic wk_on;
  logic wake_hit;

  // ----------------------------------------------------------------
  // mode control
  // ----------------------------------------------------------------
  always_comb begin
    next_pm = pm;
    next_xs = xs;
    next_field = field;
    next_err = err;
    next_armed = armed;
    next_cfg = cfg;
    next_woken = woken;
    next_sil = sil;
    next_irq = 1'b0;
    wake_hit = 1'b0;
    // decode already drops selective wake while the error flag is set
    swk_on = ((xs == XS_SWK) || (xs == XS_RXS) || (xs == XS_NMS)) && !woken;
    wk_on = (xs == XS_WK) && !woken;

    // clear first so that any set below wins in the same cycle
    // error flag cannot be cleared with selective wake chosen and no valid config
    if (link.err_clr && !(field[MODE_MSB] && !cfg)) begin
      next_err = 1'b0;
    end
    if (wake_pattern_i) begin
      next_sil = 1'b0;
    end

    case (pm)
      PM_NORMAL: begin
        if (link.cfg_set) begin
          next_cfg = 1'b1;
        end
        if (link.mode_wr) begin
          next_field = link.mode_wdata;
          if (link.mode_wdata != field) begin
            next_woken = 1'b0;
          end
          if (cswm_is_swk(link.mode_wdata)) begin
            if (cfg) begin
              next_err = 1'b0;
              next_armed = 1'b1;
            end else begin
              next_err = 1'b1;
            end
          end
        end
        // config registers changed under an enabled selective wake
        if (cfg_clear_i && cswm_is_swk(field)) begin
          next_err = 1'b1;
          next_armed = 1'b0;
        end
        if (link.pm_req) begin
          case (link.pm_code)
            PM_STOP: begin
              next_pm = PM_STOP;
              next_xs = (field == MODE_NRM) ? XS_WK : cswm_decode(field, err);
            end
            PM_SLEEP: begin
              next_pm = PM_SLEEP;
              next_woken = 1'b0;
              if ((field == MODE_RXO) || (field == MODE_NRM)) begin
                next_field = MODE_WK;
                next_xs = XS_WK;
              end else if (cswm_is_swk(field)) begin
                next_field = MODE_SWK;
                next_xs = err ? XS_WK : XS_SWK;
              end else begin
                next_xs = cswm_decode(field, err);
              end
            end
            PM_RESTART: begin
              next_pm = PM_RESTART;
              if ((field == MODE_RXO) || (field == MODE_NRM)) begin
                next_field = MODE_WK;
                next_xs = XS_WK;
              end else if (cswm_is_swk(field)) begin
                next_field = MODE_SWK;
                next_err = 1'b1;
                next_xs = XS_WK;
              end else begin
                next_xs = cswm_decode(field, err);
              end
            end
            default: begin
              next_pm = PM_NORMAL;
            end
          endcase
        end
      end
      PM_STOP, PM_RESTART: begin
        // low-power and restart ignore mode writes
        if (link.pm_req && (link.pm_code == PM_NORMAL)) begin
          next_pm = PM_NORMAL;
        end
      end
      PM_SLEEP: begin
        if (other_wake_i) begin
          next_pm = PM_RESTART;
        end
      end
      default: begin
        next_pm = PM_NORMAL;
      end
    endcase

    // wake events
    if (swk_on && wake_frame_i) begin
      wake_hit = 1'b1;
      next_armed = 1'b0;
      if (pm == PM_SLEEP) begin
        next_cfg = 1'b0;
        next_field = MODE_SWK;
      end
    end
    if (swk_on && err_overflow_i) begin
      wake_hit = 1'b1;
      next_err = 1'b1;
      next_armed = 1'b0;
    end
    if (wk_on && wake_pattern_i) begin
      wake_hit = 1'b1;
      if (err) begin
        next_armed = 1'b0;
      end
    end
    if (wake_hit) begin
      next_woken = 1'b1;
      if (pm == PM_SLEEP) begin
        next_pm = PM_RESTART;
      end else begin
        next_irq = 1'b1;
      end
    end
    if (swk_on && bus_idle_i) begin
      next_sil = 1'b1;
    end
    if (!next_field[MODE_MSB]) begin
      next_armed = 1'b0;
    end
    // in normal power the transceiver follows the field live
    if (next_pm == PM_NORMAL) begin
      next_xs = cswm_decode(next_field, next_err);
    end
  end

  // ----------------------------------------------------------------
  // pin path
  // ----------------------------------------------------------------
  always_comb begin
    case (xs)
      XS_RXO, XS_RXS, XS_NRM, XS_NMS: next_rxd = bus_rx_i;
      // wake indication only outside the receive modes, so never case
      default: next_rxd = woken ? WAKE_LOW : BUS_RECESSIVE;
    endcase
    next_tx = ((xs == XS_NRM) || (xs == XS_NMS)) ? txd_i : BUS_RECESSIVE;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pm <= PM_NORMAL;
      xs <= XS_OFF;
      field <= MODE_OFF0;
      err <= 1'b0;
      armed <= 1'b0;
      cfg <= 1'b0;
      woken <= 1'b0;
      sil <= 1'b0;
      irq <= 1'b0;
      rxd <= BUS_RECESSIVE;
      tx <= BUS_RECESSIVE;
    end else begin
      pm <= next_pm;
      xs <= next_xs;
      field <= next_field;
      err <= next_err;
      armed <= next_armed;
      cfg <= next_cfg;
      woken <= next_woken;
      sil <= next_sil;
      irq <= next_irq;
      rxd <= next_rxd;
      tx <= next_tx;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign link.mode_rd = field;
  assign link.err_flag = err;
  assign link.armed_flag = armed;
  assign link.cfg_valid = cfg;
  assign link.silence_flag = sil;
  assign link.pm_state = pm;
  assign link.xcvr_state = xs;
  assign link.wake_irq = irq;
  assign rxd_o = rxd;
  assign bus_tx_o = tx;
  assign woken_o = woken;

endmodule : cswm_device

`default_nettype wire

// ### core/cswm_pkg.sv
/*
  Shared constants, types and mode-mapping functions for the CAN
  selective-wake mode controller (device end and host end).
  Assumes both ends run on the same clock and import this package.
*/
package cswm_pkg;

  // ----------------------------------------------------------------
  // mode field codes
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_OFF0 = 3'h0;
  localparam logic [2:0] MODE_WK = 3'h1;
  localparam logic [2:0] MODE_RXO = 3'h2;
  localparam logic [2:0] MODE_NRM = 3'h3;
  localparam logic [2:0] MODE_OFF4 = 3'h4;
  localparam logic [2:0] MODE_SWK = 3'h5;
  localparam logic [2:0] MODE_RXS = 3'h6;
  localparam logic [2:0] MODE_NMS = 3'h7;
  localparam int MODE_MSB = 2;

  localparam logic BUS_RECESSIVE = 1'b1;
  localparam logic WAKE_LOW = 1'b0;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {PM_NORMAL, PM_STOP, PM_SLEEP, PM_RESTART} cswm_pm_t;
  typedef enum logic [2:0] {XS_OFF, XS_WK, XS_SWK, XS_RXO, XS_RXS, XS_NRM, XS_NMS} cswm_xs_t;
  typedef enum logic [2:0] {OP_WRITE, OP_CLR_ERR, OP_SET_CFG, OP_POWER, OP_ARM_SLEEP,
                            OP_REARM} cswm_op_t;

  // ----------------------------------------------------------------
  // mode helpers
  // ----------------------------------------------------------------
  function automatic logic cswm_is_swk(input logic [2:0] m);
    return m[MODE_MSB] && (m != MODE_OFF4);
  endfunction : cswm_is_swk

  // transceiver mode from field; a set error flag drops selective wake
  function automatic cswm_xs_t cswm_decode(input logic [2:0] m, input logic err);
    cswm_xs_t x;
    x = XS_OFF;
    case (m)
      MODE_WK: x = XS_WK;
      MODE_RXO: x = XS_RXO;
      MODE_NRM: x = XS_NRM;
      MODE_SWK: x = err ? XS_WK : XS_SWK;
      MODE_RXS: x = err ? XS_RXO : XS_RXS;
      MODE_NMS: x = err ? XS_NRM : XS_NMS;
      default: x = XS_OFF;
    endcase
    return x;
  endfunction : cswm_decode

endpackage : cswm_pkg

// ### core/cswm_if.sv
/*
  Link between host end and device end of the mode controller.
  Assumes both ends share one clock; no clocking block.
*/
`timescale 1ns/1ps
`default_nettype none

interface cswm_if;
  import cswm_pkg::*;
  logic mode_wr;
  logic [2:0] mode_wdata;
  logic err_clr;
  logic cfg_set;
  logic pm_req;
  cswm_pm_t pm_code;
  logic [2:0] mode_rd;
  logic err_flag;
  logic armed_flag;
  logic cfg_valid;
  logic silence_flag;
  cswm_pm_t pm_state;
  cswm_xs_t xcvr_state;
  logic wake_irq;

  modport dev (
    input mode_wr, mode_wdata, err_clr, cfg_set, pm_req, pm_code,
    output mode_rd, err_flag, armed_flag, cfg_valid, silence_flag, pm_state,
    xcvr_state, wake_irq
  );
  modport hst (
    output mode_wr, mode_wdata, err_clr, cfg_set, pm_req, pm_code,
    input mode_rd, err_flag, armed_flag, cfg_valid, silence_flag, pm_state,
    xcvr_state, wake_irq
  );
endinterface : cswm_if

`default_nettype wire

// ### core/cswm_host.sv
/*
  Host end: turns user operations into one-cycle link strobes, including
  the re-arm-and-sleep and rearm sequences.
  Assumes the device end samples strobes on the next clk_i edge.
*/
`timescale 1ns/1ps
`default_nettype none

module cswm_host
  import cswm_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  cswm_if.hst link,
  input wire logic op_valid_i,
  input wire cswm_op_t op_i,
  input wire logic [2:0] data_i,
  input wire cswm_pm_t pm_i,
  output logic busy_o,
  output logic refused_o,
  output logic [2:0] mode_o,
  output logic err_o,
  output logic wake_o
);

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {HS_IDLE, HS_ARM_CFG, HS_ARM_CLR, HS_ARM_WR, HS_ARM_SLP,
                            HS_REARM} cswm_hs_t;

  cswm_hs_t hs, next_hs;
  logic wr, next_wr;
  logic [2:0] wd, next_wd;
  logic clr, next_clr;
  logic cset, next_cset;
  logic preq, next_preq;
  cswm_pm_t pc, next_pc;
  logic [2:0] tgt, next_tgt;
  logic refd, next_refd;
  logic normal;

  always_comb begin
    next_hs = hs;
    next_wr = 1'b0;
    next_wd = wd;
    next_clr = 1'b0;
    next_cset = 1'b0;
    next_preq = 1'b0;
    next_pc = pc;
    next_tgt = tgt;
    next_refd = 1'b0;
    normal = (link.pm_state == PM_NORMAL);
    case (hs)
      HS_IDLE: begin
        if (op_valid_i) begin
          // low power or restart: only a return to normal is sent
          if (!normal && !((op_i == OP_POWER) && (pm_i == PM_NORMAL))) begin
            next_refd = 1'b1;
          end else begin
            case (op_i)
              OP_WRITE: begin
                next_wr = 1'b1;
                next_wd = data_i;
              end
              OP_CLR_ERR: next_clr = 1'b1;
              OP_SET_CFG: next_cset = 1'b1;
              OP_POWER: begin
                next_preq = 1'b1;
                next_pc = pm_i;
              end
              OP_ARM_SLEEP: begin
                next_wr = 1'b1;
                next_wd = MODE_WK;
                next_hs = HS_ARM_CFG;
              end
              OP_REARM: begin
                next_wr = 1'b1;
                next_wd = (data_i == MODE_OFF0) ? MODE_OFF4 : MODE_OFF0;
                next_tgt = data_i;
                next_hs = HS_REARM;
              end
              default: next_refd = 1'b1;
            endcase
          end
        end
      end
      HS_ARM_CFG: begin
        next_cset = 1'b1;
        next_hs = HS_ARM_CLR;
      end
      HS_ARM_CLR: begin
        next_clr = 1'b1;
        next_hs = HS_ARM_WR;
      end
      HS_ARM_WR: begin
        next_wr = 1'b1;
        next_wd = MODE_SWK;
        next_hs = HS_ARM_SLP;
      end
      HS_ARM_SLP: begin
        next_preq = 1'b1;
        next_pc = PM_SLEEP;
        next_hs = HS_IDLE;
      end
      HS_REARM: begin
        next_wr = 1'b1;
        next_wd = tgt;
        next_hs = HS_IDLE;
      end
      default: next_hs = HS_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hs <= HS_IDLE;
      wr <= 1'b0;
      wd <= MODE_OFF0;
      clr <= 1'b0;
      cset <= 1'b0;
      preq <= 1'b0;
      pc <= PM_NORMAL;
      tgt <= MODE_OFF0;
      refd <= 1'b0;
    end else begin
      hs <= next_hs;
      wr <= next_wr;
      wd <= next_wd;
      clr <= next_clr;
      cset <= next_cset;
      preq <= next_preq;
      pc <= next_pc;
      tgt <= next_tgt;
      refd <= next_refd;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign link.mode_wr = wr;
  assign link.mode_wdata = wd;
  assign link.err_clr = clr;
  assign link.cfg_set = cset;
  assign link.pm_req = preq;
  assign link.pm_code = pc;
  assign busy_o = (hs != HS_IDLE);
  assign refused_o = refd;
  assign mode_o = link.mode_rd;
  assign err_o = link.err_flag;
  assign wake_o = link.wake_irq;

endmodule : cswm_host

`default_nettype wire

// ### test/cswm_monitor.sv
/*
  Checker for the host/device link of the mode controller.
  Assumes one clock domain and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none

module cswm_monitor
  import cswm_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic mode_wr,
  input wire logic [2:0] mode_wdata,
  input wire logic err_clr,
  input wire logic pm_req,
  input wire cswm_pm_t pm_code,
  input wire logic [2:0] mode_rd,
  input wire logic err_flag,
  input wire logic armed_flag,
  input wire logic cfg_valid,
  input wire cswm_pm_t pm_state,
  input wire cswm_xs_t xcvr_state,
  input wire logic wake_irq
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ------------------------------------------------------------
  // expected mappings
  // ------------------------------------------------------------
  function automatic cswm_xs_t xs_of(input logic [2:0] m, input logic e);
    case (m)
      3'h1: return XS_WK;
      3'h2: return XS_RXO;
      3'h3: return XS_NRM;
      3'h5: return e ? XS_WK : XS_SWK;
      3'h6: return e ? XS_RXO : XS_RXS;
      3'h7: return e ? XS_NRM : XS_NMS;
      default: return XS_OFF;
    endcase
  endfunction : xs_of

  // sleep and restart share one field mapping
  function automatic logic [2:0] lp_field(input logic [2:0] m);
    if (m == 3'h0 || m == 3'h4) return m;
    return m[2] ? 3'h5 : 3'h1;
  endfunction : lp_field

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  armed_clr_a: assert property (armed_flag && mode_wr && !mode_wdata[2] &&
    pm_state == PM_NORMAL |=> !armed_flag) else $error("armed flag kept");
  low_pwr_hold_a: assert property (pm_state != PM_NORMAL |=> $stable(mode_rd))
    else $error("mode field changed in low power");
  norm_decode_a: assert property (pm_state == PM_NORMAL |->
    xcvr_state == xs_of(mode_rd, err_flag)) else $error("normal decode wrong");
  // mapping is fixed at the entry edge; a later error event must not trip this
  stop_map_a: assert property (pm_req && pm_code == PM_STOP && pm_state == PM_NORMAL
    |=> xcvr_state == ($past(mode_rd) == 3'h3 ? XS_WK :
    xs_of($past(mode_rd), $past(err_flag)))) else $error("stop mode wrong");
  stop_entry_a: assert property (pm_req && pm_code == PM_STOP && pm_state == PM_NORMAL
    |=> pm_state == PM_STOP && $stable(mode_rd)) else $error("stop entry wrong");
  sleep_entry_a: assert property (pm_req && pm_code == PM_SLEEP && pm_state == PM_NORMAL
    |=> pm_state == PM_SLEEP && mode_rd == lp_field($past(mode_rd)))
    else $error("sleep entry wrong");
  restart_map_a: assert property (pm_req && pm_code == PM_RESTART && pm_state == PM_NORMAL
    |=> pm_state == PM_RESTART && mode_rd == lp_field($past(mode_rd)) &&
    err_flag == (($past(mode_rd) > 3'h4) || $past(err_flag))) else $error("restart wrong");
  err_clear_a: assert property (err_clr && !mode_wr && pm_state == PM_NORMAL &&
    (!mode_rd[2] || cfg_valid) |=> !err_flag) else $error("error flag not cleared");
  irq_pulse_a: assert property (wake_irq |=> !wake_irq)
    else $error("wake interrupt longer than one cycle");

  sleep_wake_c: cover property (pm_state == PM_SLEEP ##1 pm_state == PM_RESTART);
  irq_c: cover property (wake_irq);
  stop_err_c: cover property (pm_state == PM_STOP && err_flag);
endmodule : cswm_monitor

`default_nettype wire

// ### test/cswm_tb_top.sv
/*
  Testbench for device and host ends joined by the link interface.
  Assumes the design package and interface are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module cswm_tb_top
  import cswm_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic op_valid_i = 1'b0;
  cswm_op_t op_i = OP_WRITE;
  logic [2:0] data_i = 3'h0;
  cswm_pm_t pm_i = PM_NORMAL;
  logic bus_rx_i = 1'b1;
  logic txd_i = 1'b1;
  logic [5:0] evt = 6'h00;
  logic busy_o, refused_o, rxd_o, bus_tx_o, woken_o;
  logic [2:0] mode_o;
  logic err_o, wake_o;
  logic irq_seen = 1'b0;
  logic ref_seen = 1'b0;
  int error_cnt = 0;
  int n_compared = 0;
  cswm_xs_t xe [8] = '{XS_OFF, XS_WK, XS_RXO, XS_NRM, XS_OFF, XS_SWK, XS_RXS, XS_NMS};

  cswm_if link ();

  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (wake_o === 1'b1) irq_seen <= 1'b1;
    if (refused_o === 1'b1) ref_seen <= 1'b1;
  end

  cswm_device u_cswm_device (.clk_i(clk_i), .rst_i(rst_i), .link(link), .bus_rx_i(bus_rx_i),
    .txd_i(txd_i), .wake_frame_i(evt[0]), .wake_pattern_i(evt[1]), .err_overflow_i(evt[2]),
    .bus_idle_i(evt[3]), .other_wake_i(evt[4]), .cfg_clear_i(evt[5]), .rxd_o(rxd_o),
    .bus_tx_o(bus_tx_o), .woken_o(woken_o));
  cswm_host u_cswm_host (.clk_i(clk_i), .rst_i(rst_i), .link(link), .op_valid_i(op_valid_i),
    .op_i(op_i), .data_i(data_i), .pm_i(pm_i), .busy_o(busy_o), .refused_o(refused_o),
    .mode_o(mode_o), .err_o(err_o), .wake_o(wake_o));
  cswm_monitor u_cswm_monitor (.clk_i(clk_i), .rst_i(rst_i), .mode_wr(link.mode_wr),
    .mode_wdata(link.mode_wdata), .err_clr(link.err_clr), .pm_req(link.pm_req),
    .pm_code(link.pm_code), .mode_rd(link.mode_rd), .err_flag(link.err_flag),
    .armed_flag(link.armed_flag), .cfg_valid(link.cfg_valid), .pm_state(link.pm_state),
    .xcvr_state(link.xcvr_state), .wake_irq(link.wake_irq));

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // entered and left 1 ns after an edge
  task automatic op(input cswm_op_t o, input logic [2:0] d, input cswm_pm_t p);
    int i;
    op_valid_i = 1'b1;
    op_i = o;
    data_i = d;
    pm_i = p;
    @(posedge clk_i);
    #1 op_valid_i = 1'b0;
    // busy is looked at off the edge, once the sequencer state has settled
    for (i = 0; i < 20 && busy_o !== 1'b0; i++) begin
      @(posedge clk_i);
      #1;
    end
    if (busy_o !== 1'b0) begin
      error_cnt++;
      $display("Error t=%0t busy %h exp %h", $time, busy_o, 1'b0);
    end
    repeat (2) @(posedge clk_i);
    #1;
  endtask : op

  task automatic pulse(input logic [5:0] v);
    evt = v;
    @(posedge clk_i);
    #1 evt = 6'h00;
    repeat (2) @(posedge clk_i);
    #1;
  endtask : pulse

  task automatic wrap_up();
    if (error_cnt == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_decode();
    op(OP_SET_CFG, 3'h0, PM_NORMAL);
    txd_i = 1'b0;
    bus_rx_i = 1'b0;
    for (int m = 0; m < 8; m++) begin
      op(OP_WRITE, m[2:0], PM_NORMAL);
      chk(link.mode_rd, m[2:0]);
      chk(mode_o, m[2:0]);
      chk(link.xcvr_state, xe[m]);
      chk(bus_tx_o, (m == 3 || m == 7) ? 8'h0 : 8'h1);
      chk(rxd_o, (m inside {2, 3, 6, 7}) ? 8'h0 : 8'h1);
      if (m > 4) chk({link.err_flag, link.armed_flag}, 8'h1);
    end
    // field now 111 with valid config: monitoring is live
    pulse(6'h08);
    chk(link.silence_flag, 8'h1);
    pulse(6'h02);
    chk({link.silence_flag, woken_o}, 8'h0);
    txd_i = 1'b1;
    bus_rx_i = 1'b1;
  endtask : t_decode

  task automatic t_stop();
    for (int m = 0; m < 8; m++) begin
      op(OP_WRITE, m[2:0], PM_NORMAL);
      op(OP_POWER, 3'h0, PM_STOP);
      chk({link.pm_state, link.mode_rd}, {PM_STOP, m[2:0]});
      chk(link.xcvr_state, m == 3 ? XS_WK : xe[m]);
      op(OP_POWER, 3'h0, PM_NORMAL);
    end
    op(OP_POWER, 3'h0, PM_STOP);
    ref_seen = 1'b0;
    op(OP_WRITE, 3'h1, PM_NORMAL);
    chk({ref_seen, link.mode_rd}, 8'hf);
    op(OP_POWER, 3'h0, PM_NORMAL);
    pulse(6'h20);
    chk({link.err_flag, link.armed_flag}, 8'h2);
    op(OP_POWER, 3'h0, PM_STOP);
    chk({link.mode_rd, link.xcvr_state}, {3'h7, XS_NRM});
    op(OP_POWER, 3'h0, PM_NORMAL);
  endtask : t_stop

  task automatic t_sleep();
    for (int m = 0; m < 8; m++) begin
      op(OP_SET_CFG, 3'h0, PM_NORMAL);
      op(OP_CLR_ERR, 3'h0, PM_NORMAL);
      op(OP_WRITE, m[2:0], PM_NORMAL);
      op(OP_POWER, 3'h0, PM_SLEEP);
      chk(link.mode_rd, m[2] ? (m == 4 ? 3'h4 : 3'h5) : (m == 0 ? 3'h0 : 3'h1));
      chk(link.xcvr_state, (m == 0 || m == 4) ? XS_OFF : m[2] ? XS_SWK : XS_WK);
      pulse(6'h10);
      op(OP_POWER, 3'h0, PM_NORMAL);
    end
    op(OP_SET_CFG, 3'h0, PM_NORMAL);
    op(OP_CLR_ERR, 3'h0, PM_NORMAL);
    op(OP_WRITE, 3'h6, PM_NORMAL);
    op(OP_POWER, 3'h0, PM_RESTART);
    chk({link.mode_rd, link.err_flag}, 8'hb);
    chk(err_o, 8'h1);
    op(OP_POWER, 3'h0, PM_NORMAL);
  endtask : t_sleep

  task automatic t_wake();
    op(OP_ARM_SLEEP, 3'h5, PM_SLEEP);
    chk({link.pm_state, link.err_flag, link.armed_flag, link.cfg_valid}, {PM_SLEEP, 3'h3});
    chk(link.xcvr_state, XS_SWK);
    pulse(6'h01);
    chk({link.pm_state, link.mode_rd, link.err_flag}, {PM_RESTART, 4'ha});
    chk({link.cfg_valid, link.armed_flag, woken_o}, 8'h1);
    op(OP_POWER, 3'h0, PM_NORMAL);
    chk(woken_o, 8'h1);
    op(OP_POWER, 3'h0, PM_SLEEP);
    chk({woken_o, link.xcvr_state}, {1'b0, XS_SWK});
    pulse(6'h01);
    op(OP_POWER, 3'h0, PM_NORMAL);
    op(OP_REARM, 3'h5, PM_NORMAL);
    chk({woken_o, link.mode_rd}, 8'h5);
    op(OP_SET_CFG, 3'h0, PM_NORMAL);
    op(OP_CLR_ERR, 3'h0, PM_NORMAL);
    op(OP_WRITE, 3'h7, PM_NORMAL);
    irq_seen = 1'b0;
    pulse(6'h01);
    chk({irq_seen, rxd_o, link.pm_state}, {2'b11, PM_NORMAL});
  endtask : t_wake

  task automatic t_overflow();
    op(OP_REARM, 3'h7, PM_NORMAL);
    chk({link.err_flag, link.armed_flag, woken_o}, 8'h2);
    irq_seen = 1'b0;
    pulse(6'h04);
    chk({irq_seen, link.err_flag, link.armed_flag, woken_o}, 8'hd);
    chk(link.xcvr_state, XS_NRM);
  endtask : t_overflow

  initial begin
    repeat (2) @(posedge clk_i);
    #1 rst_i = 1'b0;
    chk({link.err_flag, link.armed_flag, link.mode_rd}, 8'h0);
    t_decode();
    t_stop();
    t_sleep();
    t_wake();
    t_overflow();
    wrap_up();
  end

  // a hang costs a mismatch; the tests need well under this span
  initial begin
    #50us;
    error_cnt++;
    wrap_up();
  end
endmodule : cswm_tb_top

`default_nettype wire
